/* design/script_param_defines.vh */
// Constants for the script primitive parameter decoder
`ifndef SCRIPT_PARAM_DEFINES_VH
`define SCRIPT_PARAM_DEFINES_VH
`define CMD_SCRIPT 8'h88
`define CMD_WRITE_BIT 8'h01
`define CMD_RESET 8'h00
`define CMD_WRITE_BYTE 8'h03
`define CMD_TRIPLET 8'h05
`define CMD_SPEED 8'h0D
`define RP_SPEED_INV_BIT 7
`define RP_SPEED_BIT 3
`define RP_IGNORE_BIT 1
`define WB_VALUE_BIT 0
`define TP_DIR_BIT 0
`define DEV_ADDR 7'h40
`define SPEED_RESET 1'b0
`endif

/* design/sync2.v */
// Two-flop synchroniser for one level
module sync2 (
  // Clock and reset
  input wire ref_clk,
  input wire resetn,
  // Level
  input wire d,
  output reg q
);
  reg meta;
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      // Pins idle high; resetting low would fake an edge
      meta <= 1'b1;
      q <= 1'b1;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

/* design/script_primitive_param_decode.v */
// Script receiver over I2C write and primitive parameter decoder
`include "script_param_defines.vh"
module script_primitive_param_decode #(
  parameter [6:0] DEV_ADDR = `DEV_ADDR
) (
  // Clock and reset
  input wire ref_clk,
  input wire resetn,
  // I2C link
  input wire scl_in,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe,
  // Bus engine results
  input wire presence,
  input wire [1:0] triplet_reads,
  // Decoded controls
  output reg speed_select,
  output reg presence_ignore,
  output reg write_bit_value,
  output reg write_bit_valid,
  output reg [7:0] write_byte_value,
  output reg write_byte_valid,
  output reg triplet_dir,
  output reg triplet_valid,
  output reg speed_param_error,
  output reg script_active,
  output reg script_halted,
  output reg [7:0] last_command
);
  // ****************************************
  // Link sampling
  // ****************************************
  wire scl_s;
  wire sda_s;
  reg scl_d;
  reg sda_d;
  sync2 u_scl (.ref_clk(ref_clk), .resetn(resetn), .d(scl_in), .q(scl_s));
  sync2 u_sda (.ref_clk(ref_clk), .resetn(resetn), .d(sda_in), .q(sda_s));
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end
  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  // Conditions need SCL high on both samples
  wire start_cond = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_cond = scl_s & scl_d & ~sda_d & sda_s;

  // ****************************************
  // Byte receiver
  // ****************************************
  localparam S_IDLE = 3'h0;
  localparam S_ADDR = 3'h1;
  localparam S_CMD = 3'h2;
  localparam S_LEN = 3'h3;
  localparam S_PRIM = 3'h4;
  localparam S_PARAM = 3'h5;
  localparam S_SKIP = 3'h6;

  reg [2:0] state;
  reg [7:0] shreg;
  reg [3:0] bitcnt;
  reg ack_phase;
  reg ack_drive;
  reg [7:0] remaining;
  reg [7:0] pending_cmd;

  // Ack drives SDA low; pin only ever pulled low, never driven high
  assign sda_out = 1'b0;
  assign sda_oe = ack_drive;

  wire [7:0] rx_byte = {shreg[6:0], sda_s};
  wire byte_done = scl_rise & ~ack_phase & (bitcnt == 4'h7);

  // Primitives that carry one parameter byte
  wire takes_param = (rx_byte == `CMD_SPEED) || (rx_byte == `CMD_WRITE_BIT) ||
    (rx_byte == `CMD_WRITE_BYTE) || (rx_byte == `CMD_TRIPLET);

  // ****************************************
  // Receiver and decoder state
  // ****************************************
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state <= S_IDLE;
      shreg <= 8'h00;
      bitcnt <= 4'h0;
      ack_phase <= 1'b0;
      ack_drive <= 1'b0;
      remaining <= 8'h00;
      pending_cmd <= 8'h00;
      speed_select <= `SPEED_RESET;
      presence_ignore <= 1'b0;
      write_bit_value <= 1'b0;
      write_bit_valid <= 1'b0;
      write_byte_value <= 8'h00;
      write_byte_valid <= 1'b0;
      triplet_dir <= 1'b0;
      triplet_valid <= 1'b0;
      speed_param_error <= 1'b0;
      script_active <= 1'b0;
      script_halted <= 1'b0;
      last_command <= 8'h00;
    end else begin
      write_bit_valid <= 1'b0;
      write_byte_valid <= 1'b0;
      triplet_valid <= 1'b0;
      if (start_cond) begin
        // A new start clears any halt
        state <= S_ADDR;
        bitcnt <= 4'h0;
        ack_phase <= 1'b0;
        ack_drive <= 1'b0;
        script_halted <= 1'b0;
      end else if (stop_cond) begin
        state <= S_IDLE;
        ack_drive <= 1'b0;
        script_active <= 1'b0;
      end else if (state != S_IDLE) begin
        if (scl_rise && !ack_phase) begin
          shreg <= rx_byte;
          bitcnt <= bitcnt + 4'h1;
        end
        if (scl_fall && ack_phase && ack_drive) begin
          ack_drive <= 1'b0;
          ack_phase <= 1'b0;
          bitcnt <= 4'h0;
        end else if (scl_fall && bitcnt == 4'h8 && !ack_phase) begin
          ack_phase <= 1'b1;
          ack_drive <= (state != S_SKIP);
          if (state == S_SKIP) begin
            ack_phase <= 1'b0;
          end
        end
        if (scl_fall && ack_phase && !ack_drive) begin
          ack_phase <= 1'b0;
          bitcnt <= 4'h0;
        end
        if (byte_done) begin
          case (state)
            S_ADDR: begin
              // Address match with write direction only
              if (rx_byte[7:1] == DEV_ADDR && !rx_byte[0]) begin
                state <= S_CMD;
              end else begin
                state <= S_SKIP;
              end
            end
            S_CMD: begin
              state <= (rx_byte == `CMD_SCRIPT) ? S_LEN : S_SKIP;
            end
            S_LEN: begin
              // Zero length is not a script
              if (rx_byte != 8'h00) begin
                remaining <= rx_byte;
                script_active <= 1'b1;
                state <= S_PRIM;
              end else begin
                state <= S_SKIP;
              end
            end
            S_PRIM: begin
              // Halted or overlong script: byte refused, no ack
              if (script_halted || remaining == 8'h00) begin
                state <= S_SKIP;
              end else begin
                remaining <= remaining - 8'h01;
                pending_cmd <= rx_byte;
                last_command <= rx_byte;
                if (takes_param) begin
                  state <= S_PARAM;
                end
                // Reset with no presence: halt unless presence is ignored
                if (rx_byte == `CMD_RESET && !presence && !presence_ignore) begin
                  script_halted <= 1'b1;
                end
              end
            end
            S_PARAM: begin
              // A parameter past the length is still taken
              remaining <= remaining - 8'h01;
              state <= S_PRIM;
              case (pending_cmd)
                `CMD_SPEED: begin
                  // Speed setting, presence ignore flag and speed error change here
                  speed_select <= rx_byte[`RP_SPEED_BIT];
                  presence_ignore <= rx_byte[`RP_IGNORE_BIT];
                  speed_param_error <= ~(rx_byte[`RP_SPEED_INV_BIT] ^
                    rx_byte[`RP_SPEED_BIT]);
                end
                `CMD_WRITE_BIT: begin
                  write_bit_value <= rx_byte[`WB_VALUE_BIT];
                  write_bit_valid <= 1'b1;
                end
                `CMD_WRITE_BYTE: begin
                  write_byte_value <= rx_byte;
                  write_byte_valid <= 1'b1;
                end
                `CMD_TRIPLET: begin
                  // Direction applies only if both reads were zero
                  triplet_dir <= (triplet_reads == 2'b00) ?
                    rx_byte[`TP_DIR_BIT] : triplet_reads[0];
                  triplet_valid <= 1'b1;
                end
                default: begin
                end
              endcase
            end
            default: begin
            end
          endcase
        end
      end
    end
  end
endmodule

/* tb/script_primitive_param_decode_asserts.sv */
// Port checks for the script parameter decoder
// ********
// Checker
// ********
module script_primitive_param_decode_asserts (
  // Clock, reset and engine results
  input wire ref_clk,
  input wire resetn,
  input wire presence,
  input wire [1:0] triplet_reads,
  // Decoded controls
  input wire speed_select,
  input wire presence_ignore,
  input wire write_bit_valid,
  input wire [7:0] write_byte_value,
  input wire write_byte_valid,
  input wire triplet_dir,
  input wire triplet_valid,
  input wire speed_param_error,
  input wire script_halted,
  input wire [7:0] last_command
);
  timeunit 1ns; timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  chk_speed_only_cmd: assert property ($changed(speed_select) |-> last_command == 8'h0D)
    else $error("speed changed outside speed primitive");
  chk_error_only_cmd: assert property ($changed(speed_param_error) |-> last_command == 8'h0D)
    else $error("speed error changed outside speed primitive");
  chk_ignore_cmd: assert property ($changed(presence_ignore) |-> last_command == 8'h0D)
    else $error("ignore flag changed outside speed primitive");
  chk_bit_cmd: assert property (write_bit_valid |-> last_command == 8'h01)
    else $error("write bit pulse without its primitive");
  chk_byte_cmd: assert property (write_byte_valid |-> last_command == 8'h03)
    else $error("write byte pulse without its primitive");
  chk_byte_hold: assert property ($changed(write_byte_value) |-> write_byte_valid)
    else $error("byte value moved without a parameter");
  chk_triplet_cmd: assert property (triplet_valid |-> last_command == 8'h05)
    else $error("triplet pulse without its primitive");
  chk_triplet_reads: assert property (triplet_valid && triplet_reads != 2'h0
    |-> triplet_dir == triplet_reads[0])
    else $error("triplet direction ignored read slots");
  chk_halt_cause: assert property ($rose(script_halted) |-> !presence_ignore && !$past(presence))
    else $error("halt without missing presence");
  // Halted scripts must not leak further write bit or write byte primitives
  chk_halt_quiet: assert property (script_halted |-> !(write_bit_valid || write_byte_valid))
    else $error("primitive issued while halted");
  cover property (write_byte_valid);
  cover property (triplet_valid && triplet_dir);
  cover property ($rose(script_halted));
endmodule
bind script_primitive_param_decode script_primitive_param_decode_asserts u_chk (.ref_clk,
  .resetn, .presence, .triplet_reads, .speed_select, .presence_ignore, .write_bit_valid,
  .write_byte_value, .write_byte_valid, .triplet_dir, .triplet_valid, .speed_param_error,
  .script_halted, .last_command);

/* tb/i2c_host_model.sv */
// Host side of the I2C link, 64 ns bit period
// ********
// Host model
// ********
module i2c_host_model (
  output logic scl,
  output logic sda_drv,
  input wire sda_oe
);
  timeunit 1ns; timeprecision 1ps;
  logic last_ack;
  initial begin
    scl = 1;
    sda_drv = 1;
    last_ack = 0;
  end
  task start;
    sda_drv = 0;
    #32 scl = 0;
    // Data may move only once SCL is low
    #16;
  endtask
  // Released SDA floats high by pull-up
  task send(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      sda_drv = b[i];
      #16 scl = 1;
      #32 scl = 0;
      #16;
    end
    sda_drv = 1;
    #16 scl = 1;
    last_ack = sda_oe;
    #32 scl = 0;
    #16;
  endtask
  task stop;
    sda_drv = 0;
    #16 scl = 1;
    #16 sda_drv = 1;
    #32;
  endtask
endmodule

/* tb/script_primitive_param_decode_test.sv */
// Self-checking bench for the script parameter decoder
// ********
// Bench
// ********
`include "script_param_defines.vh"
module script_primitive_param_decode_test;
  timeunit 1ns; timeprecision 1ps;
  logic ref_clk = 0, resetn = 0, presence = 0;
  logic [1:0] triplet_reads = 2'h0;
  wire scl, sda_drv, sda_out, sda_oe, speed_select, presence_ignore, write_bit_value;
  wire write_bit_valid, write_byte_valid, triplet_dir, triplet_valid, speed_param_error;
  wire script_active, script_halted;
  wire [7:0] write_byte_value, last_command;
  wire sda = sda_drv & ~sda_oe;
  int fail_count = 0, n_tests = 0;
  always #4 ref_clk = ~ref_clk;
  i2c_host_model host (.scl, .sda_drv, .sda_oe);
  script_primitive_param_decode dut (.ref_clk, .resetn, .scl_in(scl), .sda_in(sda), .sda_out,
    .sda_oe, .presence, .triplet_reads, .speed_select, .presence_ignore, .write_bit_value,
    .write_bit_valid, .write_byte_value, .write_byte_valid, .triplet_dir, .triplet_valid,
    .speed_param_error, .script_active, .script_halted, .last_command);
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task setin(input logic p, input logic [1:0] r);
    @(posedge ref_clk);
    #1 presence = p;
    triplet_reads = r;
  endtask
  // Fixed-zero parameter bits stay zero in every script
  task run(input logic [31:0] s, input int n);
    @(posedge ref_clk);
    #1 host.start();
    host.send({`DEV_ADDR, 1'b0});
    host.send(`CMD_SCRIPT);
    host.send(8'(n));
    chk(script_active, 1'b1);
    for (int i = 0; i < n; i++) host.send(s[31 - 8 * i -: 8]);
    host.stop();
    chk(host.last_ack, 1'b1);
    chk(script_active, 1'b0);
  endtask
  // Refused openings: read address, foreign command, zero length
  task t_refuse;
    @(posedge ref_clk);
    #1 host.start();
    host.send({`DEV_ADDR, 1'b1});
    chk(host.last_ack, 1'b0);
    host.stop();
    host.start();
    host.send({`DEV_ADDR, 1'b0});
    host.send(8'h87);
    chk(host.last_ack, 1'b0);
    host.send(`CMD_SPEED);
    host.send(8'h08);
    host.stop();
    chk(speed_select, 1'b0);
    chk(script_active, 1'b0);
    host.start();
    host.send({`DEV_ADDR, 1'b0});
    host.send(`CMD_SCRIPT);
    host.send(8'h00);
    chk(host.last_ack, 1'b0);
    host.stop();
    chk(script_active, 1'b0);
  endtask
  task t_speed;
    run({`CMD_SPEED, 8'h08, 16'h0}, 2);
    chk(speed_select, 1'b1);
    chk(speed_param_error, 1'b0);
    run({`CMD_SPEED, 8'h88, 16'h0}, 2);
    chk(speed_param_error, 1'b1);
    run({`CMD_SPEED, 8'h80, 16'h0}, 2);
    chk(speed_select, 1'b0);
    chk(speed_param_error, 1'b0);
  endtask
  task t_write;
    run({`CMD_WRITE_BIT, 8'h01, `CMD_WRITE_BYTE, 8'hA5}, 4);
    chk(write_bit_value, 1'b1);
    chk(write_byte_value, 8'hA5);
    chk(speed_select, 1'b0);
  endtask
  task t_triplet;
    setin(1'b1, 2'h0);
    run({`CMD_TRIPLET, 8'h01, 16'h0}, 2);
    chk(triplet_dir, 1'b1);
    run({`CMD_TRIPLET, 8'h00, 16'h0}, 2);
    chk(triplet_dir, 1'b0);
    setin(1'b1, 2'h2);
    run({`CMD_TRIPLET, 8'h01, 16'h0}, 2);
    chk(triplet_dir, 1'b0);
  endtask
  task t_presence;
    setin(1'b0, 2'h0);
    run({`CMD_SPEED, 8'h0A, `CMD_RESET, 8'h0}, 3);
    chk(presence_ignore, 1'b1);
    chk(script_halted, 1'b0);
    run({`CMD_SPEED, 8'h08, `CMD_RESET, 8'h0}, 3);
    chk(script_halted, 1'b1);
    setin(1'b1, 2'h0);
    run({`CMD_SPEED, 8'h08, `CMD_RESET, 8'h0}, 3);
    chk(script_halted, 1'b0);
  endtask
  task tally_and_finish;
    $display("checks %0d errors %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge ref_clk);
    #1 resetn = 1;
    repeat (4) @(posedge ref_clk);
    t_speed();
    t_write();
    t_refuse();
    t_triplet();
    t_presence();
    tally_and_finish();
  end
  // Runs take about 38 us; allow a wide margin
  initial begin
    #400000;
    fail_count++;
    tally_and_finish();
  end
endmodule
